// *** hdl/xmem_pkg.sv ***
// Constants, types and register layout for the external data memory interface.
package xmem_pkg;
	// Register indices on the plain register port
	localparam logic [1:0] REG_PAGE = 2'h0;
	localparam logic [1:0] REG_CFG = 2'h1;
	localparam logic [1:0] REG_TIM = 2'h2;
	localparam logic [1:0] REG_STAT = 2'h3;
	// Reset values
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'h03;
	localparam logic [7:0] TIM_RESET = 8'hff;
	// Config bits that exist; 7:6 read zero
	localparam logic [7:0] CFG_MASK = 8'h3f;
	// Memory mode codes
	localparam logic [1:0] MODE_INTERNAL = 2'h0;
	localparam logic [1:0] MODE_SPLIT = 2'h1;
	localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
	localparam logic [1:0] MODE_EXTERNAL = 2'h3;
	// Mux select value that shares address and data pins
	localparam logic MUX_SHARED = 1'b0;
	// On-chip boundary and alias mask
	localparam logic [15:0] ONCHIP_LIMIT = 16'h2000;
	localparam logic [15:0] ONCHIP_MASK = 16'h1fff;
	localparam int ONCHIP_WORDS = 8192;
	// Fixed overhead split before and after the programmed phases
	localparam logic [4:0] LEAD_CYC = 5'h02;
	localparam logic [4:0] TAIL_CYC = 5'h02;
	// Status bit positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_OFF = 1;

	// Config register layout
	typedef struct packed {
		logic [1:0] unused;
		logic port_sel;
		logic mux_mode_select;
		logic [1:0] memory_mode_select;
		logic [1:0] latch_pulse_width_sel;
	} config_t;

	// Timing register layout
	typedef struct packed {
		logic [1:0] addr_setup_sel;
		logic [3:0] strobe_width_sel;
		logic [1:0] addr_hold_sel;
	} timing_t;

	// External bus pin group
	typedef struct packed {
		logic [7:0] addr_hi;
		logic addr_hi_oe;
		logic [7:0] addr_lo;
		logic addr_lo_oe;
		logic [7:0] ad_out;
		logic ad_oe;
		logic ale;
		logic rd_n;
		logic wr_n;
	} bus_pins_t;

	// Sequencer phases
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_LEAD,
		PH_ALE_HI,
		PH_ALE_LO,
		PH_SETUP,
		PH_STROBE,
		PH_HOLD,
		PH_TAIL
	} phase_t;
endpackage : xmem_pkg

// *** hdl/bus_sequencer.sv ***
// Phase sequencer that times one off-chip access.
`timescale 1ns/1ns
`default_nettype none
module bus_sequencer import xmem_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic mux_shared,
	input wire logic [1:0] ale_sel,
	input wire timing_t tim,
	output phase_t phase_q,
	output logic last_q,
	output logic done_q
);
	// Cycles left in the current phase
	logic [4:0] cnt_q;

	// Length of each phase in clocks
	function automatic logic [4:0] plen(input phase_t p);
		case (p)
			PH_LEAD: plen = LEAD_CYC;
			PH_ALE_HI, PH_ALE_LO: plen = mux_shared ? 5'(ale_sel) + 5'h01 : 5'h00;
			PH_SETUP: plen = 5'(tim.addr_setup_sel);
			PH_STROBE: plen = 5'(tim.strobe_width_sel) + 5'h01;
			PH_HOLD: plen = 5'(tim.addr_hold_sel);
			PH_TAIL: plen = TAIL_CYC;
			default: plen = 5'h01;
		endcase
	endfunction : plen

	// Fixed phase order
	function automatic phase_t succ(input phase_t p);
		case (p)
			PH_LEAD: succ = PH_ALE_HI;
			PH_ALE_HI: succ = PH_ALE_LO;
			PH_ALE_LO: succ = PH_SETUP;
			PH_SETUP: succ = PH_STROBE;
			PH_STROBE: succ = PH_HOLD;
			PH_HOLD: succ = PH_TAIL;
			default: succ = PH_IDLE;
		endcase
	endfunction : succ

	// Next phase with non-zero length; zero codes skip cleanly
	function automatic phase_t advance(input phase_t p);
		phase_t n;
		logic found;
		n = p;
		found = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (!found) begin
				n = succ(n);
				found = (n == PH_IDLE) || (plen(n) != 5'h00);
			end
		end
		advance = n;
	endfunction : advance

	// Phase and count walk; total is programmed sum plus four
	always_ff @(posedge clk) begin
		if (reset) begin
			phase_q <= PH_IDLE;
			cnt_q <= 5'h00;
		end else if (phase_q == PH_IDLE) begin
			if (start) begin
				phase_q <= PH_LEAD;
				cnt_q <= LEAD_CYC - 5'h01;
			end
		end else if (cnt_q != 5'h00) begin
			cnt_q <= cnt_q - 5'h01;
		end else begin
			phase_q <= advance(phase_q);
			cnt_q <= plen(advance(phase_q)) - 5'h01;
		end
	end

	// Flags for the last strobe cycle and the end of access
	always_ff @(posedge clk) begin
		if (reset) begin
			last_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			// Final strobe count; the pins show this cycle one clock later
			last_q <= (phase_q == PH_STROBE) && (cnt_q == 5'h00);
			done_q <= (phase_q == PH_TAIL) && (cnt_q == 5'h00);
		end
	end
endmodule : bus_sequencer
`default_nettype wire

// *** hdl/ext_data_mem_interface.sv ***
// Top of the external data memory interface with on-chip RAM.
`timescale 1ns/1ns
`default_nettype none
module ext_data_mem_interface import xmem_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// CPU data move request
	input wire logic move_req,
	input wire logic move_write,
	input wire logic move_wide,
	input wire logic [15:0] data_pointer,
	input wire logic [7:0] indirect_pointer,
	input wire logic [7:0] move_wdata,
	output logic move_busy,
	output logic move_done,
	output logic [7:0] move_rdata,
	// External bus
	input wire logic [7:0] ad_in,
	output bus_pins_t pins
);
	// Access walk, seen from the request edge:
	// - On-chip moves finish in one clock; the done pulse follows the take edge.
	// - Off-chip moves run lead, latch high, latch low, setup, strobe, hold, tail.
	// - Lead and tail are fixed at two clocks each, so four clocks of overhead.
	// - Latch phases only exist with shared pins; zero-length phases are skipped.
	// - Pins are registered, so the bus lags the sequencer by one clock.
	// - The done pulse lags the sequencer end by one more clock.
	// - Read data are taken in the last strobe cycle seen on the pins.
	// Limitation: the CPU side must wait for done; requests while busy are lost.
	// Trade-off: timing is frozen per access, so writes to the timing register
	// during a transfer only affect the next one.
	// Software registers
	logic [7:0] ram_page_select_q;
	config_t ext_mem_config_q;
	timing_t ext_mem_timing_ctrl_q;
	// Timing frozen at access start
	timing_t tim_snap_q;
	logic mux_snap_q;
	logic [1:0] ale_snap_q;
	// Access context
	logic [15:0] addr_q;
	logic drive_hi_q;
	logic write_q;
	logic [7:0] wdata_q;
	logic off_q;
	logic busy_q;
	// On-chip RAM
	logic [7:0] ram_q [ONCHIP_WORDS];
	logic [12:0] ram_addr;
	// Output flops
	logic [7:0] rdata_q;
	logic [7:0] move_rdata_q;
	logic done_q;
	bus_pins_t pins_q;
	// Sequencer wires
	phase_t phase;
	logic last_strobe;
	logic seq_done;
	// Request decode
	logic take;
	logic [15:0] eff_addr;
	logic go_off;
	logic hi_drive;

	assign take = move_req && !busy_q;
	assign ram_addr = 13'(eff_addr & ONCHIP_MASK);

	// Effective address: 8-bit moves pair page and pointer
	always_comb begin
		if (move_wide) begin
			eff_addr = data_pointer;
		end else begin
			eff_addr = {ram_page_select_q, indirect_pointer};
		end
	end

	// Routing summary:
	// - Mode 00 keeps every move on-chip, aliased on the 8K boundary.
	// - Modes 01 and 10 split at the boundary; 10 also drives the upper lines.
	// - Mode 11 sends every move off-chip and ignores the page register.
	// Boundary taken as the first off-chip address.
	// Route and upper-line drive by memory mode
	always_comb begin
		go_off = 1'b0;
		hi_drive = move_wide;
		case (ext_mem_config_q.memory_mode_select)
			MODE_INTERNAL: begin
				// Everything aliases into on-chip space
				go_off = 1'b0;
			end
			MODE_SPLIT: begin
				// Upper lines left to the port latches on 8-bit moves
				go_off = eff_addr >= ONCHIP_LIMIT;
				hi_drive = move_wide;
			end
			MODE_SPLIT_BANK: begin
				// Bank select always drives all sixteen lines
				go_off = eff_addr >= ONCHIP_LIMIT;
				hi_drive = 1'b1;
			end
			MODE_EXTERNAL: begin
				// On-chip RAM hidden; page register ignored
				go_off = 1'b1;
				hi_drive = move_wide;
			end
			default: begin
				go_off = 1'b0;
			end
		endcase
	end

	// Register port notes:
	// - Writes land on the strobe edge, reads answer one clock later.
	// - Config bits 7:6 do not exist and read back as zero.
	// - Status is read-only; writes to it are dropped.
	// Page select register
	always_ff @(posedge clk) begin
		if (reset) begin
			ram_page_select_q <= PAGE_RESET;
		end else if (reg_wr && reg_addr == REG_PAGE) begin
			ram_page_select_q <= reg_wdata;
		end
	end

	// Config register; unused bits stay zero
	always_ff @(posedge clk) begin
		if (reset) begin
			ext_mem_config_q <= config_t'(CFG_RESET);
		end else if (reg_wr && reg_addr == REG_CFG) begin
			ext_mem_config_q <= config_t'(reg_wdata & CFG_MASK);
		end
	end

	// Timing register starts at longest settings
	always_ff @(posedge clk) begin
		if (reset) begin
			ext_mem_timing_ctrl_q <= timing_t'(TIM_RESET);
		end else if (reg_wr && reg_addr == REG_TIM) begin
			ext_mem_timing_ctrl_q <= timing_t'(reg_wdata);
		end
	end

	// Read data stands one cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_PAGE: rdata_q <= ram_page_select_q;
				REG_CFG: rdata_q <= ext_mem_config_q;
				REG_TIM: rdata_q <= ext_mem_timing_ctrl_q;
				REG_STAT: begin
					rdata_q <= 8'h00;
					rdata_q[STAT_BUSY] <= busy_q;
					rdata_q[STAT_OFF] <= off_q;
				end
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			// Zero outside the answer cycle
			rdata_q <= 8'h00;
		end
	end

	// Freeze timing so a mid-access write cannot stretch it
	always_ff @(posedge clk) begin
		if (reset) begin
			tim_snap_q <= timing_t'(TIM_RESET);
			mux_snap_q <= 1'b1;
			ale_snap_q <= 2'h0;
		end else if (take && go_off) begin
			tim_snap_q <= ext_mem_timing_ctrl_q;
			mux_snap_q <= ext_mem_config_q.mux_mode_select;
			ale_snap_q <= ext_mem_config_q.latch_pulse_width_sel;
		end
	end

	// Access context held for the whole transfer
	always_ff @(posedge clk) begin
		if (reset) begin
			addr_q <= 16'h0000;
			drive_hi_q <= 1'b0;
			write_q <= 1'b0;
			wdata_q <= 8'h00;
			off_q <= 1'b0;
		end else if (take) begin
			addr_q <= eff_addr;
			drive_hi_q <= hi_drive;
			write_q <= move_write;
			wdata_q <= move_wdata;
			off_q <= go_off;
		end
	end

	// Set and clear cannot meet: a take needs busy low, the end needs it high
	// Busy from off-chip request until the done pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_q <= 1'b0;
		end else if (take && go_off) begin
			busy_q <= 1'b1;
		end else if (seq_done) begin
			busy_q <= 1'b0;
		end
	end

	// The on-chip RAM has no reset; its contents are undefined until written
	// On-chip RAM write; one-cycle access
	always_ff @(posedge clk) begin
		if (take && !go_off && move_write) begin
			ram_q[ram_addr] <= move_wdata;
		end
	end

	// Done is one clock long; the next request may arrive beside it
	// Move result and done pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			move_rdata_q <= 8'h00;
			done_q <= 1'b0;
		end else begin
			done_q <= (take && !go_off) || seq_done;
			if (take && !go_off && !move_write) begin
				move_rdata_q <= ram_q[ram_addr];
			end else if (last_strobe && !write_q) begin
				// Sampled in the final strobe cycle
				move_rdata_q <= ad_in;
			end
		end
	end

	// The sequencer sees only snapped settings, never the live registers
	// Off-chip timing engine
	bus_sequencer u_seq (
		.clk(clk),
		.reset(reset),
		.start(take && go_off),
		.mux_shared(mux_snap_q == MUX_SHARED),
		.ale_sel(ale_snap_q),
		.tim(tim_snap_q),
		.phase_q(phase),
		.last_q(last_strobe),
		.done_q(seq_done)
	);

	// Pin plan per phase:
	// - Idle: strobes high, latch low, every enable off.
	// - Latch phases: low address on the shared pins, latch pulse high first.
	// - Setup to hold: write data driven on the data pins for writes only.
	// - Strobe: read or write strobe low for the programmed width.
	// - Upper lines: driven on 16-bit moves and on every move in mode 10, else left to ports.
	// Separate-pin mode keeps the low address on its own pins throughout.
	// Pin drive per phase; registered so pins come from flops
	always_ff @(posedge clk) begin
		if (reset) begin
			pins_q <= '0;
			pins_q.rd_n <= 1'b1;
			pins_q.wr_n <= 1'b1;
		end else if (phase == PH_IDLE) begin
			// Bus released between accesses
			pins_q <= '0;
			pins_q.rd_n <= 1'b1;
			pins_q.wr_n <= 1'b1;
		end else begin
			pins_q.addr_hi <= addr_q[15:8];
			pins_q.addr_hi_oe <= drive_hi_q;
			pins_q.ale <= phase == PH_ALE_HI;
			pins_q.rd_n <= !(phase == PH_STROBE && !write_q);
			pins_q.wr_n <= !(phase == PH_STROBE && write_q);
			if (mux_snap_q == MUX_SHARED) begin
				// Shared pins: address while latching, then data
				pins_q.addr_lo <= 8'h00;
				pins_q.addr_lo_oe <= 1'b0;
				if (phase == PH_ALE_HI || phase == PH_ALE_LO) begin
					pins_q.ad_out <= addr_q[7:0];
					pins_q.ad_oe <= 1'b1;
				end else if (write_q && (phase == PH_SETUP ||
					phase == PH_STROBE || phase == PH_HOLD)) begin
					pins_q.ad_out <= wdata_q;
					pins_q.ad_oe <= 1'b1;
				end else begin
					pins_q.ad_out <= 8'h00;
					pins_q.ad_oe <= 1'b0;
				end
			end else begin
				// Separate pins: address held the whole access
				pins_q.addr_lo <= addr_q[7:0];
				pins_q.addr_lo_oe <= 1'b1;
				pins_q.ad_out <= write_q ? wdata_q : 8'h00;
				pins_q.ad_oe <= write_q && (phase == PH_SETUP ||
					phase == PH_STROBE || phase == PH_HOLD);
			end
		end
	end

	// Outputs straight from flops
	assign reg_rdata = rdata_q;
	assign move_busy = busy_q;
	assign move_done = done_q;
	assign move_rdata = move_rdata_q;
	assign pins = pins_q;
endmodule : ext_data_mem_interface
`default_nettype wire

// *** tb/xmem_checker.sv ***
// Port assertions for the external data memory interface.
`timescale 1ns/1ns
`default_nettype none
module xmem_checker import xmem_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic move_req,
	input wire logic move_wide,
	input wire logic [15:0] data_pointer,
	input wire logic move_busy,
	input wire logic move_done,
	input wire bus_pins_t pins
);
	config_t cfg_q; // Shadow of config
	timing_t tim_q; // Shadow of timing
	logic [7:0] page_q; // Shadow of page
	logic [15:0] dp_q; // Pointer of the current move
	logic wide_q; // Width of the current move
	logic [5:0] acc_q; // Cycles since the move was taken
	logic [5:0] str_q; // Strobe low run
	logic [5:0] ale_q; // Latch high run
	logic strb; // Either strobe active
	int t_off; // Take-to-done distance off-chip
	assign strb = !pins.rd_n || !pins.wr_n;
	// Overhead of four plus one strobe cycle plus done lag
	always_comb begin
		t_off = 6 + tim_q.addr_setup_sel + tim_q.strobe_width_sel + tim_q.addr_hold_sel;
		if (cfg_q.mux_mode_select == MUX_SHARED) t_off = t_off + 2 * (cfg_q.latch_pulse_width_sel + 1);
	end
	// Shadows follow software writes only; moves snap them at start
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_q <= CFG_RESET;
			tim_q <= TIM_RESET;
			page_q <= PAGE_RESET;
		end else if (reg_wr) begin
			if (reg_addr == REG_CFG) cfg_q <= reg_wdata;
			if (reg_addr == REG_TIM) tim_q <= reg_wdata;
			if (reg_addr == REG_PAGE) page_q <= reg_wdata;
		end
	end
	// Move capture and run counters
	always_ff @(posedge clk) begin
		if (move_req && !move_busy) begin
			dp_q <= data_pointer;
			wide_q <= move_wide;
			acc_q <= 6'h00;
		end else acc_q <= acc_q + 6'h01;
		str_q <= strb ? str_q + 6'h01 : 6'h00;
		ale_q <= pins.ale ? ale_q + 6'h01 : 6'h00;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	strobe_excl_a: assert property (pins.rd_n || pins.wr_n)
		else $error("read and write strobes together");
	ale_quiet_a: assert property (pins.ale |-> pins.rd_n && pins.wr_n && !pins.addr_lo_oe)
		else $error("latch phase overlaps strobe");
	strobe_len_a: assert property ($fell(strb) |-> str_q == tim_q.strobe_width_sel + 1)
		else $error("strobe width wrong");
	ale_len_a: assert property ($fell(pins.ale) |-> ale_q == cfg_q.latch_pulse_width_sel + 1)
		else $error("latch pulse width wrong");
	offchip_len_a: assert property (move_done && $past(move_busy) |-> acc_q == t_off)
		else $error("off-chip move length wrong");
	route_once_a: assert property (move_req && !move_busy |=> move_done != move_busy)
		else $error("move neither on-chip nor off-chip");
	idle_quiet_a: assert property (!move_busy |-> pins.rd_n && pins.wr_n && !pins.ale)
		else $error("bus active while idle");
	hi_drive_a: assert property (strb |-> pins.addr_hi_oe ==
		(cfg_q.memory_mode_select == MODE_SPLIT_BANK || wide_q)) else $error("upper drive wrong");
	hi_value_a: assert property (strb && pins.addr_hi_oe |->
		pins.addr_hi == (wide_q ? dp_q[15:8] : page_q)) else $error("upper address wrong");
	// Main scenarios
	mux_cov: cover property (move_done && $past(move_busy) && cfg_q.mux_mode_select == MUX_SHARED);
	onchip_cov: cover property (move_done && !$past(move_busy));
	narrow_cov: cover property (strb && !pins.addr_hi_oe);
endmodule : xmem_checker
`default_nettype wire

// *** tb/sram_model.sv ***
// Behavioural external SRAM with its address latch.
`timescale 1ns/1ns
`default_nettype none
module sram_model import xmem_pkg::*; (
	input wire logic clk,
	input wire bus_pins_t pins,
	input wire logic [7:0] port_hi,
	output logic [7:0] ad_in,
	output logic [15:0] seen_addr
);
	logic [7:0] mem [65536]; // Storage
	logic [7:0] lat_q; // External address latch
	logic [7:0] last_q; // Last byte driven
	logic [15:0] a; // Address the memory sees
	// Undriven upper lines show the port latch value
	assign a = {pins.addr_hi_oe ? pins.addr_hi : port_hi, pins.addr_lo_oe ? pins.addr_lo : lat_q};
	// Released bus shows the inverse, so a stale copy never passes
	assign ad_in = !pins.rd_n ? mem[a] : ~last_q;
	// Latch open while the pulse is high, holds after it falls
	always_ff @(posedge clk) begin
		if (pins.ale) lat_q <= pins.ad_oe ? pins.ad_out : ~pins.ad_out;
		if (!pins.wr_n) mem[a] <= pins.ad_oe ? pins.ad_out : ~pins.ad_out;
		if (!pins.rd_n) last_q <= mem[a];
		if (!pins.rd_n || !pins.wr_n) seen_addr <= a;
	end
endmodule : sram_model
`default_nettype wire

// *** tb/ext_data_mem_interface_tb_top.sv ***
// Self-checking bench for the external data memory interface.
`timescale 1ns/1ns
`default_nettype none
module ext_data_mem_interface_tb_top import xmem_pkg::*;;
	logic clk = 1'b0; // 25 MHz clock
	logic reset = 1'b1; // Synchronous reset
	logic reg_wr = 1'b0, reg_rd = 1'b0; // Register strobes
	logic [1:0] reg_addr = 2'h0; // Register index
	logic [7:0] reg_wdata = 8'h00, reg_rdata; // Register data
	logic move_req = 1'b0, move_write = 1'b0, move_wide = 1'b0; // Move request
	logic [15:0] data_pointer = 16'h0000, seen_addr; // Pointer and bus address
	logic [7:0] indirect_pointer = 8'h00, move_wdata = 8'h00, move_rdata; // Move data
	logic [7:0] ad_in, cf, tm; // Bus data and current settings
	logic [7:0] port_hi = 8'h77; // Port latch value on undriven lines
	logic move_busy, move_done; // Move status
	bus_pins_t pins; // External bus
	int error_cnt = 0, n_checks = 0, n, i; // Counters
	always #20 clk = ~clk;
	ext_data_mem_interface uut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .move_req, .move_write, .move_wide, .data_pointer, .indirect_pointer,
		.move_wdata, .move_busy, .move_done, .move_rdata, .ad_in, .pins);
	sram_model mem (.clk, .pins, .port_hi, .ad_in, .seen_addr);
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	// One-cycle register write
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Register read, data stands only in the next cycle
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk({8'h00, reg_rdata}, {8'h00, e});
	endtask : rd
	task automatic set(input logic [7:0] c, input logic [7:0] t);
		cf = c;
		tm = t;
		wr(2'h1, c);
		wr(2'h2, t);
	endtask : set
	// Take-to-done distance of an off-chip move
	function automatic int tx(input logic [7:0] c, input logic [7:0] t);
		return 6 + t[7:6] + t[5:2] + t[1:0] + (c[4] ? 0 : 2 * (c[1:0] + 1));
	endfunction : tx
	// One move; bounded wait for done, then length and read data
	task automatic mv(input logic w, input logic wd, input logic [15:0] dp,
		input logic [7:0] ip, input logic [7:0] d, input logic [7:0] e, input int x);
		@(posedge clk);
		move_req <= 1'b1;
		move_write <= w;
		move_wide <= wd;
		data_pointer <= dp;
		indirect_pointer <= ip;
		move_wdata <= d;
		@(posedge clk);
		move_req <= 1'b0;
		// Count edges after the take edge until done is seen settled
		#1;
		n = 0;
		while (move_done !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(16'(n), 16'(x));
		if (n >= 100) finish_test();
		if (!w) chk({8'h00, move_rdata}, {8'h00, e});
	endtask : mv
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		rd(2'h2, 8'hff);
		rd(2'h1, 8'h03);
		rd(2'h0, 8'h00);
		wr(2'h1, 8'hff);
		rd(2'h1, 8'h3f);
		wr(2'h3, 8'hff);
		rd(2'h3, 8'h00);
		$display("test registers done");
		set(8'h18, 8'h00);
		wr(2'h0, 8'h40);
		mv(1'b1, 1'b0, 16'h0000, 8'h12, 8'ha5, 8'h00, 6);
		chk(seen_addr, 16'h4012);
		mv(1'b0, 1'b0, 16'h0000, 8'h12, 8'h00, 8'ha5, 6);
		wr(2'h0, 8'h10);
		mv(1'b1, 1'b0, 16'h0000, 8'h12, 8'h3c, 8'h00, 0);
		mv(1'b0, 1'b1, 16'h1012, 8'h00, 8'h00, 8'h3c, 0);
		mv(1'b1, 1'b1, 16'h8001, 8'h00, 8'h5a, 8'h00, 6);
		chk(seen_addr, 16'h8001);
		$display("test split with page done");
		set(8'h1c, 8'h00);
		mv(1'b1, 1'b0, 16'h0000, 8'h12, 8'hc3, 8'h00, 6);
		chk(seen_addr, 16'h7712);
		mv(1'b1, 1'b1, 16'h0012, 8'h00, 8'h69, 8'h00, 6);
		chk(seen_addr, 16'h0012);
		mv(1'b0, 1'b1, 16'h0012, 8'h00, 8'h00, 8'h69, 6);
		$display("test external only done");
		// Both mux settings and mode codes 01, 10 and 11, with timing codes spread out
		for (i = 0; i < 6; i++) begin
			set({3'h0, 1'(i / 3), 2'(i % 3 + 1), 2'(i)}, {2'(i), 4'(i * 3), 2'(i)});
			mv(1'b1, 1'b1, 16'h9000 + 16'(i), 8'h00, 8'h80 + 8'(i), 8'h00, tx(cf, tm));
			mv(1'b0, 1'b1, 16'h9000 + 16'(i), 8'h00, 8'h00, 8'h80 + 8'(i), tx(cf, tm));
		end
		$display("test timing done");
		set(8'h10, 8'h00);
		mv(1'b1, 1'b1, 16'h2005, 8'h00, 8'h77, 8'h00, 0);
		mv(1'b0, 1'b1, 16'h0005, 8'h00, 8'h00, 8'h77, 0);
		set(8'h14, 8'h00);
		wr(2'h0, 8'h40);
		mv(1'b1, 1'b0, 16'h0000, 8'h34, 8'h11, 8'h00, 6);
		chk(seen_addr, 16'h7734);
		mv(1'b0, 1'b1, 16'h0005, 8'h00, 8'h00, 8'h77, 0);
		$display("test internal and split done");
		finish_test();
	end
endmodule : ext_data_mem_interface_tb_top
bind ext_data_mem_interface xmem_checker chk_u (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
	.move_req, .move_wide, .data_pointer, .move_busy, .move_done, .pins);
`default_nettype wire
